// File: hw/sfes_pkg.sv
// Package for the superframe extension scheduler: constants, codes and carrier types.
// Assumes a single 50 MHz clock domain and an AHB-Lite register bus.
package sfes_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] SFES_OFF_CTRL = 8'h00;
  localparam logic [7:0] SFES_OFF_SPACING = 8'h04;
  localparam logic [7:0] SFES_OFF_DURATION = 8'h08;
  localparam logic [7:0] SFES_OFF_FRAMES = 8'h0c;
  localparam logic [7:0] SFES_OFF_FRAMELEN = 8'h10;
  localparam logic [7:0] SFES_OFF_AUX = 8'h14;
  localparam logic [7:0] SFES_OFF_STATUS = 8'h18;
  localparam logic [7:0] SFES_OFF_SIGNAL = 8'h1c;

  // ----------------------------------------------------------------
  // Control field positions
  // ----------------------------------------------------------------
  localparam int SFES_CTRL_RUN = 0;
  localparam int SFES_CTRL_EXTEN = 1;
  localparam int SFES_CTRL_MULTI = 2;
  localparam int SFES_CTRL_LITE = 3;
  localparam int SFES_CTRL_EXTCODE_LSB = 4;
  localparam int SFES_CTRL_AUX1_LSB = 8;

  // ----------------------------------------------------------------
  // Field widths and reset values
  // ----------------------------------------------------------------
  localparam int SFES_DUR_W = 22;
  localparam int SFES_SPC_W = 8;
  localparam int SFES_NFR_W = 8;
  localparam int SFES_FLEN_W = 24;
  localparam int SFES_AUXN_W = 4;
  localparam logic [31:0] SFES_CTRL_RST = 32'h0000_0020;
  localparam logic [SFES_SPC_W-1:0] SFES_SPC_RST = 8'h01;
  localparam logic [SFES_DUR_W-1:0] SFES_DUR_RST = 22'h00_0100;
  localparam logic [SFES_NFR_W-1:0] SFES_NFR_RST = 8'h02;
  localparam logic [SFES_FLEN_W-1:0] SFES_FLEN_RST = 24'h00_0100;
  localparam logic [3:0] SFES_EXT_TYPE = 4'h0;

  // ----------------------------------------------------------------
  // Preamble format codes
  // ----------------------------------------------------------------
  localparam logic [2:0] SFES_FMT_BASE_SINGLE = 3'h0;
  localparam logic [2:0] SFES_FMT_BASE_MULTI = 3'h1;
  localparam logic [2:0] SFES_FMT_PRO_EXT = 3'h2;
  localparam logic [2:0] SFES_FMT_LITE_SINGLE = 3'h3;
  localparam logic [2:0] SFES_FMT_LITE_MULTI = 3'h4;
  localparam logic [2:0] SFES_AUX1_PRO = 3'h0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int SFES_CLK_MHZ = 50;
  localparam int SFES_EXT_MAX_MS = 250;
  localparam longint SFES_EXT_MAX_CYC = longint'(SFES_EXT_MAX_MS) * 1000 * SFES_CLK_MHZ;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SFES_IDLE = 2'b00,
    SFES_BASE = 2'b01,
    SFES_EXT = 2'b11
  } sfes_state_t;

  typedef struct packed {
    logic [2:0] formatField;
    logic [3:0] auxField;
    logic isExtension;
  } sfes_preamble_t;

  typedef struct packed {
    logic [3:0] extensionTypeField;
    logic [SFES_DUR_W-1:0] extensionDurationPeriods;
    logic [SFES_SPC_W-1:0] extensionSpacingFrames;
  } sfes_post_t;

  function automatic logic [2:0] sfesBaseFormat(input logic lite, input logic multi);
    if (lite) begin
      return multi ? SFES_FMT_LITE_MULTI : SFES_FMT_LITE_SINGLE;
    end
    return multi ? SFES_FMT_BASE_MULTI : SFES_FMT_BASE_SINGLE;
  endfunction

endpackage

// File: hw/sfes_ahb_slave.sv
// AHB-Lite register slave for the superframe extension scheduler.
// Assumes single-word transfers from one master; always answers OKAY with no wait state.
`timescale 1ns/100ps
`default_nettype none
module sfes_ahb_slave
  import sfes_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic wrStrobe,
  output logic [7:0] wrAddr,
  output logic [31:0] wrData,
  output logic [7:0] rdAddr,
  input wire logic [31:0] rdData
);

  logic pendWrite;
  logic [7:0] pendAddr;
  logic take;

  // ----------------------------------------------------------------
  // Address phase capture
  // ----------------------------------------------------------------
  assign take = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign rdAddr = haddr[7:0];

  always_ff @(posedge mclk) begin
    if (rst) begin
      pendWrite <= 1'b0;
      pendAddr <= 8'h00;
    end else begin
      pendWrite <= take && hwrite && (hsize == 3'h2);
      pendAddr <= haddr[7:0];
    end
  end

  // Read data is registered so it stands through the whole data phase.
  always_ff @(posedge mclk) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      hrdata <= rdData;
    end
  end

  assign wrStrobe = pendWrite;
  assign wrAddr = pendAddr;
  assign wrData = hwdata;

endmodule // sfes_ahb_slave
`default_nettype wire

// File: hw/sfes_scheduler.sv
// Superframe extension scheduler: sequences base frames and extension parts,
// and produces preamble codes and signalling fields for the frame builder.
// Assumes one 50 MHz clock where one cycle is one elementary sample period.
`timescale 1ns/100ps
`default_nettype none

module sfes_scheduler
  import sfes_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic preambleStart,
  output sfes_preamble_t preamble,
  output logic baseActive,
  output logic extActive,
  output logic superframeStart,
  output logic auxPowerMatch,
  output logic auxMultiBlock,
  output logic [SFES_AUXN_W-1:0] auxLoopCount,
  output logic auxLoopPresent,
  output sfes_post_t postSignalling,
  output logic [SFES_NFR_W-1:0] framesPerSuperframe
);

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic wrStrobe;
  logic [7:0] wrAddr;
  logic [31:0] wrData;
  logic [7:0] rdAddr;
  logic [31:0] rdData;
  logic [31:0] ctrl;
  logic [SFES_SPC_W-1:0] spacing;
  logic [SFES_DUR_W-1:0] duration;
  logic [SFES_NFR_W-1:0] numFrames;
  logic [SFES_FLEN_W-1:0] frameLen;
  logic [SFES_AUXN_W-1:0] auxCount;
  logic [1:0] auxFlags;
  logic [SFES_DUR_W-1:0] durClamp;
  logic overLimit;

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  sfes_ahb_slave u_bus (
    .mclk(mclk),
    .rst(rst),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .wrStrobe(wrStrobe),
    .wrAddr(wrAddr),
    .wrData(wrData),
    .rdAddr(rdAddr),
    .rdData(rdData)
  );

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl <= SFES_CTRL_RST;
      spacing <= SFES_SPC_RST;
      duration <= SFES_DUR_RST;
      numFrames <= SFES_NFR_RST;
      frameLen <= SFES_FLEN_RST;
      auxCount <= '0;
      auxFlags <= 2'b11;
    end else if (wrStrobe) begin
      unique case (wrAddr)
        SFES_OFF_CTRL: ctrl <= {20'h0_0000, wrData[11:0]};
        SFES_OFF_SPACING: spacing <= wrData[SFES_SPC_W-1:0];
        SFES_OFF_DURATION: duration <= wrData[SFES_DUR_W-1:0];
        SFES_OFF_FRAMES: numFrames <= wrData[SFES_NFR_W-1:0];
        SFES_OFF_FRAMELEN: frameLen <= wrData[SFES_FLEN_W-1:0];
        SFES_OFF_AUX: begin
          auxCount <= wrData[SFES_AUXN_W-1:0];
          auxFlags <= wrData[9:8];
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Duration limit
  // ----------------------------------------------------------------
  // A duration past 250 ms is clamped rather than refused, so the link keeps running.
  // At this clock a 22-bit duration cannot reach the limit; the clamp only matters on a slower clock.
  assign overLimit = 64'(duration) > 64'(SFES_EXT_MAX_CYC);
  assign durClamp = overLimit ? SFES_DUR_W'(SFES_EXT_MAX_CYC) : duration;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  sfes_state_t state;
  sfes_state_t next_state;
  logic [SFES_FLEN_W-1:0] periodCnt;
  logic [SFES_NFR_W-1:0] frameCnt;
  logic [SFES_SPC_W-1:0] spaceCnt;
  logic [15:0] superCnt;
  logic lastPeriod;
  logic extEnable;
  logic extDue;
  logic frameDone;
  logic lastFrame;

  // The period, frame and spacing counters each end one short of their limit, so one test serves all three.
  function automatic logic sfesAtLast(input logic [SFES_FLEN_W-1:0] count, input logic [SFES_FLEN_W-1:0] limit);
    return count == limit - 1'b1;
  endfunction

  assign extEnable = ctrl[SFES_CTRL_EXTEN] && (spacing != '0);
  assign lastPeriod = (state == SFES_BASE) ? sfesAtLast(periodCnt, frameLen)
                                           : sfesAtLast(periodCnt, SFES_FLEN_W'(durClamp));
  assign frameDone = (state == SFES_BASE) && lastPeriod;
  assign lastFrame = sfesAtLast(SFES_FLEN_W'(frameCnt), SFES_FLEN_W'(numFrames));
  assign extDue = extEnable && sfesAtLast(SFES_FLEN_W'(spaceCnt), SFES_FLEN_W'(spacing));

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      SFES_IDLE: begin
        if (ctrl[SFES_CTRL_RUN] && numFrames != '0) begin
          next_state = SFES_BASE;
        end
      end
      SFES_BASE: begin
        if (frameDone) begin
          if (extDue) begin
            next_state = SFES_EXT;
          end else if (lastFrame && !ctrl[SFES_CTRL_RUN]) begin
            next_state = SFES_IDLE;
          end
        end
      end
      SFES_EXT: begin
        if (lastPeriod) begin
          next_state = (lastFrame && !ctrl[SFES_CTRL_RUN]) ? SFES_IDLE : SFES_BASE;
        end
      end
      default: next_state = SFES_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= SFES_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------
  // Period counter restarts at every first preamble, giving preamble-to-preamble timing.
  always_ff @(posedge mclk) begin
    if (rst) begin
      periodCnt <= '0;
    end else if (state == SFES_IDLE || lastPeriod) begin
      periodCnt <= '0;
    end else begin
      periodCnt <= periodCnt + 1'b1;
    end
  end

  // Frame and spacing counters restart at each superframe so the pattern repeats.
  always_ff @(posedge mclk) begin
    if (rst || state == SFES_IDLE) begin
      frameCnt <= '0;
      spaceCnt <= '0;
    end else if (frameDone) begin
      frameCnt <= lastFrame ? '0 : frameCnt + 1'b1;
      spaceCnt <= (extDue || lastFrame) ? '0 : spaceCnt + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Superframe count
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      superCnt <= 16'h0000;
    end else if (frameDone && lastFrame) begin
      superCnt <= superCnt + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Preamble and signalling outputs
  // ----------------------------------------------------------------
  logic startNow;
  logic startExt;
  logic [2:0] baseFmt;
  logic [2:0] extFmt;
  logic mixed;

  assign startNow = (state == SFES_IDLE && next_state == SFES_BASE) || (state != SFES_IDLE && lastPeriod
                    && next_state != SFES_IDLE);
  assign startExt = (next_state == SFES_EXT);
  assign baseFmt = sfesBaseFormat(ctrl[SFES_CTRL_LITE], ctrl[SFES_CTRL_MULTI]);
  // A requested code equal to the base code or a reserved code falls back to the professional code.
  assign extFmt = (ctrl[6:4] == baseFmt || ctrl[6:4] > SFES_FMT_LITE_MULTI) ? SFES_FMT_PRO_EXT
                  : ctrl[6:4];
  assign mixed = extEnable;

  // ----------------------------------------------------------------
  // Preamble registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      preambleStart <= 1'b0;
      superframeStart <= 1'b0;
    end else begin
      preambleStart <= startNow;
      superframeStart <= startNow && !startExt && (state == SFES_IDLE || frameCnt == '0 && state == SFES_EXT
                         || frameDone && lastFrame);
    end
  end

  // The preamble word holds until the next first preamble, so software can read it back at leisure.
  always_ff @(posedge mclk) begin
    if (rst) begin
      preamble <= '0;
    end else if (startNow) begin
      preamble.isExtension <= startExt;
      preamble.formatField <= startExt ? extFmt : baseFmt;
      preamble.auxField <= {(startExt && extFmt == SFES_FMT_PRO_EXT) ? SFES_AUX1_PRO : ctrl[10:8],
                            mixed};
    end
  end

  // ----------------------------------------------------------------
  // Activity levels
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      baseActive <= 1'b0;
      extActive <= 1'b0;
    end else begin
      baseActive <= (next_state == SFES_BASE);
      extActive <= (next_state == SFES_EXT);
    end
  end

  // ----------------------------------------------------------------
  // Signalling fields
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      postSignalling <= '0;
      framesPerSuperframe <= '0;
    end else begin
      postSignalling.extensionTypeField <= SFES_EXT_TYPE;
      postSignalling.extensionDurationPeriods <= durClamp;
      postSignalling.extensionSpacingFrames <= spacing;
      framesPerSuperframe <= numFrames;
    end
  end

  // ----------------------------------------------------------------
  // Auxiliary stream flags
  // ----------------------------------------------------------------
  // Power match is forced while streams exist, since mismatched cells would upset receiver gain control.
  always_ff @(posedge mclk) begin
    if (rst) begin
      auxLoopCount <= '0;
      auxLoopPresent <= 1'b0;
      auxPowerMatch <= 1'b0;
      auxMultiBlock <= 1'b0;
    end else begin
      auxLoopCount <= auxCount;
      auxLoopPresent <= (auxCount != '0);
      auxPowerMatch <= auxFlags[0] || (auxCount != '0);
      auxMultiBlock <= auxFlags[1];
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    unique case (rdAddr)
      SFES_OFF_CTRL: rdData = ctrl;
      SFES_OFF_SPACING: rdData = {24'h00_0000, spacing};
      SFES_OFF_DURATION: rdData = {10'h000, duration};
      SFES_OFF_FRAMES: rdData = {24'h00_0000, numFrames};
      SFES_OFF_FRAMELEN: rdData = {8'h00, frameLen};
      SFES_OFF_AUX: rdData = {22'h00_0000, auxFlags, 4'h0, auxCount};
      SFES_OFF_STATUS: rdData = {superCnt, frameCnt, overLimit, 5'h00, state};
      SFES_OFF_SIGNAL: rdData = {24'h00_0000, preamble};
      default: rdData = 32'h0000_0000;
    endcase
  end

endmodule // sfes_scheduler
`default_nettype wire

// File: test/sfes_checker.sv
// Checker for the superframe extension scheduler: assertions on the top ports.
// Assumes the single mclk domain and the synchronous active-high rst.
`timescale 1ns/100ps
`default_nettype none
module sfes_checker
  import sfes_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic preambleStart,
  input wire sfes_preamble_t preamble,
  input wire logic baseActive,
  input wire logic extActive,
  input wire logic superframeStart,
  input wire sfes_post_t postSignalling
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // Helper state
  // ----------------------------------------------------------------
  // Remembers the kind and base code of the last preamble, so that one
  // extension part can be compared with the base frame before it.
  logic lastExt;
  logic [2:0] baseFmt;
  always_ff @(posedge mclk) begin
    if (rst) lastExt <= 1'b0;
    else if (preambleStart) lastExt <= preamble.isExtension;
  end
  always_ff @(posedge mclk) begin
    if (rst) baseFmt <= 3'h0;
    else if (preambleStart && !preamble.isExtension) baseFmt <= preamble.formatField;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  chk_ext_then_base: assert property (preambleStart && lastExt |-> !preamble.isExtension)
    else $error("extension part not followed by a base frame");
  chk_ext_code_differs: assert property (preambleStart && preamble.isExtension
    |-> preamble.formatField != baseFmt)
    else $error("extension format code equals base code");
  chk_no_reserved: assert property (preambleStart |-> preamble.formatField <= 3'h4)
    else $error("reserved format code sent");
  chk_base_code: assert property (preambleStart && !preamble.isExtension
    |-> preamble.formatField inside {3'h0, 3'h1, 3'h3, 3'h4})
    else $error("base frame format code wrong");
  chk_mixed_ext: assert property (preambleStart && preamble.isExtension |-> preamble.auxField[0])
    else $error("mixed bit clear in extension preamble");
  chk_type_zero: assert property (postSignalling.extensionTypeField == 4'h0)
    else $error("extension type field not zero");
  chk_parts_apart: assert property (!(baseActive && extActive))
    else $error("base frame and extension part overlap");
  chk_sf_base: assert property (superframeStart |-> preambleStart && !preamble.isExtension)
    else $error("superframe does not open with a base frame");
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus slave stalled or answered an error");
endmodule // sfes_checker
bind sfes_scheduler sfes_checker sfes_checker_i (.mclk(mclk), .rst(rst), .hreadyout(hreadyout),
  .hresp(hresp), .preambleStart(preambleStart), .preamble(preamble), .baseActive(baseActive),
  .extActive(extActive), .superframeStart(superframeStart), .postSignalling(postSignalling));
`default_nettype wire

// File: test/sfes_rx_model.sv
// Receiver model: detects preambles, times them and counts extension parts.
// Assumes the scheduler's preamble outputs on the mclk domain.
`timescale 1ns/100ps
`default_nettype none
module sfes_rx_model
  import sfes_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic preambleStart,
  input wire sfes_preamble_t preamble,
  output logic [31:0] gap,
  output logic [7:0] extCount
);
  logic [31:0] cnt;
  // Periods since the last preamble, so part lengths are measured start to start.
  always_ff @(posedge mclk) begin
    if (rst || preambleStart) cnt <= 32'h0;
    else cnt <= cnt + 32'h1;
  end
  assign gap = cnt + 32'h1;
  // Extension parts are detected by preamble alone; contents are never decoded.
  always_ff @(posedge mclk) begin
    if (rst) extCount <= 8'h0;
    else if (preambleStart && preamble.isExtension) extCount <= extCount + 8'h1;
  end
endmodule // sfes_rx_model
`default_nettype wire

// File: test/tb.sv
// Testbench for the superframe extension scheduler.
// Assumes the design, the checker bind and the receiver model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb
  import sfes_pkg::*;
;
  typedef struct {
    logic [31:0] ctrl;
    logic [7:0] spc;
    logic [7:0] nfr;
    logic [23:0] flen;
    logic [21:0] dur;
    logic [2:0] bf;
    logic [2:0] ef;
  } sfes_row_t;
  logic mclk, rst, hsel, hwrite, hready, hreadyout, hresp, preambleStart, baseActive, extActive;
  logic superframeStart, auxPowerMatch, auxMultiBlock, auxLoopPresent;
  logic [31:0] haddr, hwdata, hrdata, r, gap;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] auxLoopCount;
  logic [7:0] framesPerSuperframe, extCount;
  sfes_preamble_t preamble;
  sfes_post_t postSignalling;
  int miscompares = 0;
  int checkCount = 0;
  int b, n;
  logic nx, px, en;
  sfes_row_t rw;
  sfes_row_t rows[7] = '{
    '{32'h23, 8'h01, 8'h02, 24'h4, 22'h3, SFES_FMT_BASE_SINGLE, SFES_FMT_PRO_EXT},
    '{32'h27, 8'h02, 8'h04, 24'h5, 22'h3, SFES_FMT_BASE_MULTI, SFES_FMT_PRO_EXT},
    '{32'h4b, 8'h01, 8'h02, 24'h4, 22'h6, SFES_FMT_LITE_SINGLE, SFES_FMT_LITE_MULTI},
    '{32'h4f, 8'h01, 8'h02, 24'h4, 22'h3, SFES_FMT_LITE_MULTI, SFES_FMT_PRO_EXT},
    '{32'h73, 8'h01, 8'h02, 24'h4, 22'h3, SFES_FMT_BASE_SINGLE, SFES_FMT_PRO_EXT},
    '{32'h21, 8'h01, 8'h03, 24'h4, 22'h3, SFES_FMT_BASE_SINGLE, SFES_FMT_PRO_EXT},
    '{32'h23, 8'h02, 8'h02, 24'h6, 22'h2, SFES_FMT_BASE_SINGLE, SFES_FMT_PRO_EXT}};
  logic [7:0] offs[9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20};
  logic [31:0] rstv[9] = '{32'h20, 32'h1, 32'h100, 32'h2, 32'h100, 32'h300, 32'h0, 32'h0, 32'h0};

  assign hready = hreadyout;
  sfes_scheduler sfes_scheduler_i (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .preambleStart(preambleStart), .preamble(preamble),
    .baseActive(baseActive), .extActive(extActive), .superframeStart(superframeStart),
    .auxPowerMatch(auxPowerMatch), .auxMultiBlock(auxMultiBlock), .auxLoopCount(auxLoopCount),
    .auxLoopPresent(auxLoopPresent), .postSignalling(postSignalling),
    .framesPerSuperframe(framesPerSuperframe));
  sfes_rx_model sfes_rx_model_i (.mclk(mclk), .rst(rst), .preambleStart(preambleStart),
    .preamble(preamble), .gap(gap), .extCount(extCount));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic stop_test;
    if (miscompares == 0 && checkCount > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [35:0] s, input logic [35:0] e);
    checkCount++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Holds each phase until hready is seen high; the watchdog ends a hang.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic doReset;
    @(posedge mclk);
    rst <= 1'b1;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
  endtask

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    stop_test;
  end

  initial begin
    rst = 1'b1; hsel = 1'b1; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0;
    for (int i = 0; i < 7; i++) begin
      rw = rows[i];
      en = rw.ctrl[1];
      doReset;
      bus(1'b1, SFES_OFF_SPACING, 32'(rw.spc), r);
      bus(1'b1, SFES_OFF_FRAMES, 32'(rw.nfr), r);
      bus(1'b1, SFES_OFF_FRAMELEN, 32'(rw.flen), r);
      bus(1'b1, SFES_OFF_DURATION, 32'(rw.dur), r);
      bus(1'b1, SFES_OFF_CTRL, rw.ctrl, r);
      @(negedge mclk);
      chk("post signalling", postSignalling, {4'h0, rw.dur, rw.spc});
      chk("frames advertised", framesPerSuperframe, rw.nfr);
      b = 0; nx = 1'b0; px = 1'b0;
      n = 2 * (rw.nfr + (en ? rw.nfr / rw.spc : 0)) + 1;
      for (int e = 0; e < n; e++) begin
        do @(negedge mclk); while (preambleStart !== 1'b1);
        if (e > 0) chk("part length", gap, px ? 32'(rw.dur) : 32'(rw.flen));
        chk("part kind", preamble.isExtension, nx);
        chk("format code", preamble.formatField, nx ? rw.ef : rw.bf);
        chk("aux field", preamble.auxField, {3'h0, en});
        chk("superframe start", superframeStart, !nx && b == 0);
        px = nx;
        if (nx) begin
          nx = 1'b0;
          if (b == rw.nfr) b = 0;
        end else begin
          b++;
          nx = en && (b % rw.spc == 0);
          if (!nx && b == rw.nfr) b = 0;
        end
      end
      chk("extensions detected", extCount, en ? 2 * rw.nfr / rw.spc : 0);
    end
    // Reset in mid-run, then register reset values and access kinds.
    doReset;
    @(negedge mclk);
    chk("active after reset", {baseActive, extActive, preambleStart}, 3'h0);
    @(posedge mclk);
    for (int i = 0; i < 9; i++) begin
      bus(1'b0, offs[i], 32'h0, r);
      chk("register reset", r, rstv[i]);
    end
    chk("aux flags", {auxPowerMatch, auxMultiBlock, auxLoopPresent}, 3'h6);
    bus(1'b1, SFES_OFF_AUX, 32'h3, r);
    bus(1'b1, SFES_OFF_STATUS, 32'hffffffff, r);
    bus(1'b0, SFES_OFF_STATUS, 32'h0, r);
    chk("read-only status", r, 32'h0);
    @(negedge mclk);
    chk("aux loop", {auxLoopPresent, auxLoopCount}, 5'h13);
    chk("aux flags written", {auxPowerMatch, auxMultiBlock}, 2'h2);
    stop_test;
  end
endmodule // tb
`default_nettype wire
